// *** logic/fsw_regs.vh ***
// register map, field positions and timing constants of the watchdog
`ifndef FSW_REGS_VH
`define FSW_REGS_VH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define FSW_AW            8
`define FSW_ADDR_CTRL     8'h00
`define FSW_ADDR_STATUS   8'h04
`define FSW_ADDR_PERIOD   8'h08
`define FSW_ADDR_IRQ_STAT 8'h0C
`define FSW_ADDR_IRQ_MASK 8'h10

// ----------------------------------------------------------------
// bus answers and reset values
// ----------------------------------------------------------------
`define FSW_RESP_OKAY     2'h0
`define FSW_RESP_SLVERR   2'h2
`define FSW_CTRL_RST      1'h0
`define FSW_MASK_RST      6'h00
`define FSW_DATA_ZERO     32'h00000000

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define FSW_CTRL_FORCE    0
`define FSW_ST_QCNT_LO    0
`define FSW_ST_QCNT_HI    1
`define FSW_ST_OK         2
`define FSW_ST_OSC        3
`define FSW_ST_SUPPLY     4
`define FSW_ST_RELAY_PIN  5
`define FSW_ST_EN_PIN     6
`define FSW_IRQ_W         6
`define FSW_IRQ_GOOD      0
`define FSW_IRQ_BAD       1
`define FSW_IRQ_DROP      2
`define FSW_IRQ_OSC       3
`define FSW_IRQ_SUPPLY    4
`define FSW_IRQ_OKCHG     5

// ----------------------------------------------------------------
// watchdog window, in time-base clocks
// ----------------------------------------------------------------
`define FSW_QCNT_MIN      2'h0
`define FSW_QCNT_MAX      2'h3
`define FSW_TRIG_RATIO    8'h64
`define FSW_LO_NOK        8'h50
`define FSW_LO_OK         8'h4F
`define FSW_HI_NOK        8'hA9
`define FSW_HI_OK         8'hAA
`define FSW_DROP          8'hFA
`define FSW_PER_ZERO      8'h00
`define FSW_PER_ONE       8'h01

// ----------------------------------------------------------------
// oscillator supervision, in system clocks
// ----------------------------------------------------------------
// 500 us at a 100 MHz system clock
`define FSW_OSC_TIMEOUT_CYC 20'hC350
`define FSW_OSC_CNT_W      20

`endif

// *** logic/pin_sync.v ***
// three-stage input synchroniser with agreement filter and rise pulse
`timescale 1ns/1ps

module pin_sync #(
	parameter W = 1
) (
	input  wire         clk_sys,
	input  wire         reset,
	input  wire [W-1:0] pin_in,
	output reg  [W-1:0] level_q,
	output reg  [W-1:0] rise_q
);
	reg [W-1:0] s1_q;
	reg [W-1:0] s2_q;
	reg [W-1:0] s3_q;
	reg [W-1:0] level_d;
	integer     i;

	always @* begin
		for (i = 0; i < W; i = i + 1) begin
			level_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : level_q[i];
		end
	end

	always @(posedge clk_sys) begin
		if (reset) begin
			s1_q    <= {W{1'b0}};
			s2_q    <= {W{1'b0}};
			s3_q    <= {W{1'b0}};
			level_q <= {W{1'b0}};
			rise_q  <= {W{1'b0}};
		end else begin
			s1_q    <= pin_in;
			s2_q    <= s1_q;
			s3_q    <= s2_q;
			level_q <= level_d;
			rise_q  <= level_d & ~level_q;
		end
	end
endmodule // pin_sync

// *** logic/failsafe_window_watchdog.v ***
// fail-safe window watchdog with relay and enable gating, AXI4-Lite regs
//
// Added by the designer: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`include "fsw_regs.vh"

// Overview of operation
// - trigger quality counter runs 0 to 3, up on good, down on bad
// - trigger rising edge clears window timer and clocks quality counter
// - quality counter reaching 3 sets window-ok and releases enable
// - no trigger within 250 time-base clocks clears counter and window-ok
// - quality counter decremented to 0 clears window-ok, enable driven
// - window-ok selects window bounds, shifted one clock for hysteresis
// - host triggers at one hundredth of the time-base frequency
// - oscillator failure clears quality counter and window-ok
// - supply fault or power-on reset returns watchdog to initial state
// - supply fault: relay off, reset low, enable driver on
// - bad trigger rate: relay off and enable driver on
// - relay driver follows relay request, pulling low when active
// - after power-up quality counter starts at 0 in fault state
// - period 80..169 clocks good, shorter too fast, longer too slow
module failsafe_window_watchdog #(
	parameter [`FSW_OSC_CNT_W-1:0] OSC_TIMEOUT_CYC = `FSW_OSC_TIMEOUT_CYC
) (
	input  wire                clk_sys,
	input  wire                reset,
	input  wire                trigger_in,
	input  wire                rc_osc_in,
	input  wire                relay_request,
	input  wire                undervolt_in,
	input  wire                overvolt_in,
	input  wire                relay_i,
	output wire                relay_o,
	output reg                 relay_oe,
	input  wire                enable_i,
	output wire                enable_o,
	output reg                 enable_oe,
	output reg                 reset_n,
	output reg                 window_ok,
	output reg                 irq,
	input  wire [`FSW_AW-1:0]  s_axi_awaddr,
	input  wire                s_axi_awvalid,
	output reg                 s_axi_awready,
	input  wire [31:0]         s_axi_wdata,
	input  wire [3:0]          s_axi_wstrb,
	input  wire                s_axi_wvalid,
	output reg                 s_axi_wready,
	output reg  [1:0]          s_axi_bresp,
	output reg                 s_axi_bvalid,
	input  wire                s_axi_bready,
	input  wire [`FSW_AW-1:0]  s_axi_araddr,
	input  wire                s_axi_arvalid,
	output reg                 s_axi_arready,
	output reg  [31:0]         s_axi_rdata,
	output reg  [1:0]          s_axi_rresp,
	output reg                 s_axi_rvalid,
	input  wire                s_axi_rready
);
	localparam [2:0] SEL_NONE = 3'h0;
	localparam [2:0] SEL_CTRL = 3'h1;
	localparam [2:0] SEL_STAT = 3'h2;
	localparam [2:0] SEL_PER  = 3'h3;
	localparam [2:0] SEL_IRQS = 3'h4;
	localparam [2:0] SEL_MASK = 3'h5;

	// ------------------------------------------------------------
	// address decode shared by read and write
	// ------------------------------------------------------------
	function [2:0] reg_sel;
		input [`FSW_AW-1:0] a;
		begin
			if (a == `FSW_ADDR_CTRL)
				reg_sel = SEL_CTRL;
			else if (a == `FSW_ADDR_STATUS)
				reg_sel = SEL_STAT;
			else if (a == `FSW_ADDR_PERIOD)
				reg_sel = SEL_PER;
			else if (a == `FSW_ADDR_IRQ_STAT)
				reg_sel = SEL_IRQS;
			else if (a == `FSW_ADDR_IRQ_MASK)
				reg_sel = SEL_MASK;
			else
				reg_sel = SEL_NONE;
		end
	endfunction

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	wire [4:0] pin_level;
	wire [4:0] pin_rise;

	pin_sync #(
		.W (5)
	) u_sync (
		.clk_sys (clk_sys),
		.reset   (reset),
		.pin_in  ({overvolt_in, undervolt_in, relay_request,
			rc_osc_in, trigger_in}),
		.level_q (pin_level),
		.rise_q  (pin_rise)
	);

	wire trig_rise    = pin_rise[0];
	wire tb_tick      = pin_rise[1];
	wire relay_req    = pin_level[2];
	wire supply_fault = pin_level[3] | pin_level[4];

	// ------------------------------------------------------------
	// oscillator supervision
	// ------------------------------------------------------------
	reg [`FSW_OSC_CNT_W-1:0] osc_cnt_q;
	reg                      osc_fail;

	always @(posedge clk_sys) begin
		if (reset) begin
			osc_cnt_q <= {`FSW_OSC_CNT_W{1'b0}};
			osc_fail  <= 1'b0;
		end else if (tb_tick) begin
			osc_cnt_q <= {`FSW_OSC_CNT_W{1'b0}};
			osc_fail  <= 1'b0;
		end else if (osc_cnt_q == OSC_TIMEOUT_CYC) begin
			osc_fail  <= 1'b1;
		end else begin
			osc_cnt_q <= osc_cnt_q + {{(`FSW_OSC_CNT_W-1){1'b0}}, 1'b1};
		end
	end

	// ------------------------------------------------------------
	// window evaluation and quality counter
	// ------------------------------------------------------------
	reg [1:0] qcnt_q;
	reg [1:0] qcnt_d;
	reg       ok_d;
	reg [7:0] per_q;
	reg [7:0] per_d;
	reg [7:0] last_q;
	reg [7:0] last_d;
	reg       ev_good;
	reg       ev_bad;
	reg       ev_drop;
	wire      in_window;

	assign in_window = window_ok ?
		(per_q >= `FSW_LO_OK  && per_q <= `FSW_HI_OK) :
		(per_q >= `FSW_LO_NOK && per_q <= `FSW_HI_NOK);

	always @* begin
		qcnt_d  = qcnt_q;
		ok_d    = window_ok;
		per_d   = per_q;
		last_d  = last_q;
		ev_good = 1'b0;
		ev_bad  = 1'b0;
		ev_drop = 1'b0;
		if (supply_fault) begin
			qcnt_d = `FSW_QCNT_MIN;
			ok_d   = 1'b0;
			per_d  = `FSW_PER_ZERO;
		end else if (osc_fail) begin
			qcnt_d = `FSW_QCNT_MIN;
			ok_d   = 1'b0;
			per_d  = `FSW_PER_ZERO;
		end else if (trig_rise) begin
			per_d  = `FSW_PER_ZERO;
			last_d = per_q;
			if (in_window) begin
				ev_good = 1'b1;
				if (qcnt_q != `FSW_QCNT_MAX)
					qcnt_d = qcnt_q + 2'h1;
			end else begin
				ev_bad = 1'b1;
				if (qcnt_q != `FSW_QCNT_MIN)
					qcnt_d = qcnt_q - 2'h1;
			end
			if (qcnt_d == `FSW_QCNT_MAX)
				ok_d = 1'b1;
			else if (ev_bad && qcnt_d == `FSW_QCNT_MIN)
				ok_d = 1'b0;
		end else if (tb_tick && per_q != `FSW_DROP) begin
			per_d = per_q + `FSW_PER_ONE;
			if (per_d == `FSW_DROP) begin
				ev_drop = 1'b1;
				qcnt_d  = `FSW_QCNT_MIN;
				ok_d    = 1'b0;
			end
		end
	end

	always @(posedge clk_sys) begin
		if (reset) begin
			qcnt_q    <= `FSW_QCNT_MIN;
			window_ok <= 1'b0;
			per_q     <= `FSW_PER_ZERO;
			last_q    <= `FSW_PER_ZERO;
		end else begin
			qcnt_q    <= qcnt_d;
			window_ok <= ok_d;
			per_q     <= per_d;
			last_q    <= last_d;
		end
	end

	// ------------------------------------------------------------
	// output drivers
	// ------------------------------------------------------------
	reg force_safe_q;
	reg pin_low_q;

	assign relay_o  = pin_low_q;
	assign enable_o = pin_low_q;

	always @(posedge clk_sys) begin
		if (reset) begin
			pin_low_q <= 1'b0;
			relay_oe  <= 1'b0;
			enable_oe <= 1'b1;
			reset_n   <= 1'b0;
		end else begin
			pin_low_q <= 1'b0;
			relay_oe  <= relay_req & ~supply_fault
				& window_ok & ~force_safe_q;
			enable_oe <= supply_fault | ~window_ok
				| force_safe_q;
			reset_n   <= ~supply_fault;
		end
	end

	// ------------------------------------------------------------
	// event capture and interrupt
	// ------------------------------------------------------------
	reg  [`FSW_IRQ_W-1:0] irq_stat_q;
	reg  [`FSW_IRQ_W-1:0] irq_stat_d;
	reg  [`FSW_IRQ_W-1:0] irq_mask_q;
	reg                   osc_fail_dq;
	reg                   supply_dq;
	wire                  rd_take;
	wire [`FSW_IRQ_W-1:0] events;

	assign rd_take = s_axi_arready & s_axi_arvalid;

	assign events = {ok_d != window_ok,
		supply_fault & ~supply_dq,
		osc_fail & ~osc_fail_dq,
		ev_drop, ev_bad, ev_good};

	always @* begin
		irq_stat_d = irq_stat_q | events;
		// a new event wins over the clear by read
		if (rd_take && reg_sel(s_axi_araddr) == SEL_IRQS)
			irq_stat_d = events;
	end

	always @(posedge clk_sys) begin
		if (reset) begin
			irq_stat_q  <= {`FSW_IRQ_W{1'b0}};
			osc_fail_dq <= 1'b0;
			supply_dq   <= 1'b0;
			irq         <= 1'b0;
		end else begin
			irq_stat_q  <= irq_stat_d;
			osc_fail_dq <= osc_fail;
			supply_dq   <= supply_fault;
			irq         <= |(irq_stat_d & irq_mask_q);
		end
	end

	// ------------------------------------------------------------
	// register read mux
	// ------------------------------------------------------------
	reg [31:0] rd_d;
	reg        rd_err;

	always @* begin
		rd_d   = `FSW_DATA_ZERO;
		rd_err = 1'b0;
		case (reg_sel(s_axi_araddr))
			SEL_CTRL: rd_d[`FSW_CTRL_FORCE] = force_safe_q;
			SEL_STAT: begin
				rd_d[`FSW_ST_QCNT_HI:`FSW_ST_QCNT_LO] = qcnt_q;
				rd_d[`FSW_ST_OK]        = window_ok;
				rd_d[`FSW_ST_OSC]       = osc_fail;
				rd_d[`FSW_ST_SUPPLY]    = supply_fault;
				rd_d[`FSW_ST_RELAY_PIN] = relay_i;
				rd_d[`FSW_ST_EN_PIN]    = enable_i;
			end
			SEL_PER:  rd_d[7:0] = last_q;
			SEL_IRQS: rd_d[`FSW_IRQ_W-1:0] = irq_stat_q;
			SEL_MASK: rd_d[`FSW_IRQ_W-1:0] = irq_mask_q;
			default:  rd_err = 1'b1;
		endcase
	end

	// ------------------------------------------------------------
	// AXI4-Lite write channel
	// ------------------------------------------------------------
	reg               aw_hold_q;
	reg               w_hold_q;
	reg [`FSW_AW-1:0] awaddr_q;
	reg [31:0]        wdata_q;
	reg [3:0]         wstrb_q;
	wire [2:0]        wsel = reg_sel(awaddr_q);

	always @(posedge clk_sys) begin
		if (reset) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `FSW_RESP_OKAY;
			aw_hold_q     <= 1'b0;
			w_hold_q      <= 1'b0;
			awaddr_q      <= {`FSW_AW{1'b0}};
			wdata_q       <= `FSW_DATA_ZERO;
			wstrb_q       <= 4'h0;
			force_safe_q  <= `FSW_CTRL_RST;
			irq_mask_q    <= `FSW_MASK_RST;
		end else begin
			if (s_axi_awready && s_axi_awvalid) begin
				aw_hold_q     <= 1'b1;
				awaddr_q      <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end else if (!aw_hold_q && !s_axi_bvalid) begin
				s_axi_awready <= 1'b1;
			end
			if (s_axi_wready && s_axi_wvalid) begin
				w_hold_q     <= 1'b1;
				wdata_q      <= s_axi_wdata;
				wstrb_q      <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end else if (!w_hold_q && !s_axi_bvalid) begin
				s_axi_wready <= 1'b1;
			end
			if (aw_hold_q && w_hold_q && !s_axi_bvalid) begin
				aw_hold_q    <= 1'b0;
				w_hold_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (wsel == SEL_NONE) ?
					`FSW_RESP_SLVERR : `FSW_RESP_OKAY;
				if (wstrb_q[0] && wsel == SEL_CTRL)
					force_safe_q <= wdata_q[`FSW_CTRL_FORCE];
				if (wstrb_q[0] && wsel == SEL_MASK)
					irq_mask_q <= wdata_q[`FSW_IRQ_W-1:0];
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// AXI4-Lite read channel
	// ------------------------------------------------------------
	always @(posedge clk_sys) begin
		if (reset) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= `FSW_DATA_ZERO;
			s_axi_rresp   <= `FSW_RESP_OKAY;
		end else if (rd_take) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rd_d;
			s_axi_rresp   <= rd_err ? `FSW_RESP_SLVERR : `FSW_RESP_OKAY;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
		end else if (!s_axi_rvalid) begin
			s_axi_arready <= 1'b1;
		end
	end
endmodule // failsafe_window_watchdog

// *** tb/fsw_properties.sv ***
// concurrent checks on the ports of the fail-safe window watchdog
`timescale 1ns/1ps

module fsw_properties #(
	parameter [19:0] OSC_TIMEOUT_CYC = 20'h0C350
) (
	input logic clk_sys,
	input logic reset,
	input logic rc_osc_in,
	input logic relay_request,
	input logic undervolt_in,
	input logic overvolt_in,
	input logic relay_oe,
	input logic enable_oe,
	input logic reset_n,
	input logic window_ok,
	input logic s_axi_arvalid,
	input logic s_axi_arready,
	input logic s_axi_rvalid
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);

	// cycles since the time base last moved
	logic [19:0] still_q;
	logic        osc_q;
	always @(posedge clk_sys) begin
		osc_q <= rc_osc_in;
		if (reset || osc_q != rc_osc_in)
			still_q <= 20'h00000;
		else if (still_q != 20'hFFFFF)
			still_q <= still_q + 20'h00001;
	end

	start_state_a: assert property ($fell(reset) |->
		!window_ok && enable_oe && !relay_oe) else $error("unsafe start");
	supply_gate_a: assert property ((undervolt_in || overvolt_in) [*8] |->
		!reset_n && !relay_oe && enable_oe) else $error("supply gate");
	relay_gate_a: assert property (relay_oe |->
		$past(window_ok) && $past(reset_n)) else $error("relay without ok");
	enable_gate_a: assert property (!enable_oe |->
		$past(window_ok) && $past(reset_n)) else $error("enable released");
	relay_follow_a: assert property (
		(window_ok && reset_n && relay_request) [*8] |-> relay_oe)
		else $error("relay not following request");
	fault_clear_a: assert property (!reset_n [*4] |-> !window_ok)
		else $error("ok kept in supply fault");
	osc_stop_a: assert property (
		still_q > OSC_TIMEOUT_CYC + 20'h00010 |-> !window_ok)
		else $error("ok kept without time base");
	read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
		s_axi_rvalid) else $error("read not answered");
endmodule // fsw_properties

bind failsafe_window_watchdog fsw_properties #(
	.OSC_TIMEOUT_CYC(OSC_TIMEOUT_CYC)
) u_props (
	.clk_sys, .reset, .rc_osc_in, .relay_request, .undervolt_in,
	.overvolt_in, .relay_oe, .enable_oe, .reset_n, .window_ok,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rvalid
);

// *** tb/host_trigger_model.sv ***
// host model sending a trigger pulse every period time-base ticks
`timescale 1ns/1ps

module host_trigger_model (
	input  logic       clk_sys,
	input  logic       rc_osc_in,
	input  logic [7:0] period,
	output logic       trigger_in
);
	logic       rc_q = 1'b0;
	logic [7:0] tick_q = 8'h00;

	initial trigger_in = 1'b0;
	// period zero stops the host
	always @(posedge clk_sys) begin
		rc_q <= rc_osc_in;
		if (period == 8'h00) begin
			tick_q <= 8'h00;
			trigger_in <= 1'b0;
		end else if (rc_osc_in && !rc_q) begin
			tick_q <= tick_q + 8'h01;
			if (tick_q + 8'h01 >= period) begin
				tick_q <= 8'h00;
				trigger_in <= 1'b1;
			end else if (tick_q == 8'h04) begin
				trigger_in <= 1'b0;
			end
		end
	end
endmodule // host_trigger_model

// *** tb/tb_top.sv ***
// self-checking testbench for the fail-safe window watchdog
`timescale 1ns/1ps
`include "fsw_regs.vh"

module tb_top;
	logic        clk_sys = 1'b0, reset = 1'b1, rc_osc_in = 1'b0;
	logic        osc_run = 1'b1, relay_request = 1'b0;
	logic        undervolt_in = 1'b0, overvolt_in = 1'b0;
	logic [3:0]  osc_div = 4'h0;
	logic [7:0]  period = 8'h00, s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h00000000;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
	logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic        trigger_in, relay_o, relay_oe, enable_o, enable_oe;
	logic        reset_n, window_ok, irq;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic        s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
	logic [31:0] s_axi_rdata, rd_data;
	int          fail_count = 0, total_checks = 0;
	wire         relay_i = ~relay_oe;
	wire         enable_i = ~enable_oe;

	always #5 clk_sys = ~clk_sys;

	// time base: one tick every 20 system clocks while running
	always @(posedge clk_sys) begin
		if (osc_run) begin
			osc_div <= (osc_div == 4'h9) ? 4'h0 : osc_div + 4'h1;
			if (osc_div == 4'h9) rc_osc_in <= ~rc_osc_in;
		end
	end

	failsafe_window_watchdog #(.OSC_TIMEOUT_CYC(20'h007D0)) u_dut (
		.clk_sys, .reset, .trigger_in, .rc_osc_in, .relay_request,
		.undervolt_in, .overvolt_in, .relay_i, .relay_o, .relay_oe,
		.enable_i, .enable_o, .enable_oe, .reset_n, .window_ok, .irq,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready
	);
	host_trigger_model u_host (.clk_sys, .rc_osc_in, .period, .trigger_in);

	task chk(input bit c, input string m);
		total_checks++;
		if (!c) begin
			fail_count++;
			$display("Error %0t %s", $time, m);
		end
	endtask

	task complete_run;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task bail(input string m);
		fail_count++;
		$display("Error %0t %s timed out", $time, m);
		complete_run();
	endtask

	task idle(input int n);
		repeat (n) @(posedge clk_sys);
	endtask

	task wait_ok(input logic v, input int lim);
		int n;
		n = 0;
		while (window_ok !== v && n < lim) begin
			@(posedge clk_sys);
			n++;
		end
		if (window_ok !== v) bail("window_ok");
	endtask

	task wr(input [7:0] a, input [31:0] d);
		int n;
		n = 0;
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk_sys);
			n++;
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1 && n < 50);
		if (s_axi_bvalid !== 1'b1) bail("write");
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task rd(input [7:0] a);
		int n;
		n = 0;
		@(posedge clk_sys);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk_sys);
			n++;
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1 && n < 50);
		if (s_axi_rvalid !== 1'b1) bail("read");
		rd_data = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	task get_ok;
		period <= `FSW_TRIG_RATIO;
		wait_ok(1'b1, 12000);
	endtask

	task t_reset;
		chk(window_ok === 1'b0 && enable_oe === 1'b1, "start");
		idle(10);
		chk(reset_n === 1'b1 && relay_oe === 1'b0, "reset out");
		rd(`FSW_ADDR_STATUS);
		chk(rd_data[2:0] === 3'h0, "status start");
		rd(`FSW_ADDR_IRQ_MASK);
		chk(rd_data === 32'h00000000, "mask reset");
		wr(`FSW_ADDR_IRQ_MASK, 32'h0000003F);
		rd(`FSW_ADDR_IRQ_MASK);
		chk(rd_data === 32'h0000003F, "mask write");
		rd(8'h40);
		chk(resp === 2'h2 && rd_data === 32'h00000000, "unmapped read");
		wr(8'h40, 32'h00000001);
		chk(resp === 2'h2, "unmapped write");
		chk(relay_o === 1'b0 && enable_o === 1'b0, "pin drive");
		s_axi_wstrb <= 4'h0;
		wr(`FSW_ADDR_IRQ_MASK, 32'h00000000);
		s_axi_wstrb <= 4'hF;
		rd(`FSW_ADDR_IRQ_MASK);
		chk(rd_data === 32'h0000003F, "strobe off write");
		$display("reset test done");
	endtask

	task t_fast;
		get_ok();
		relay_request <= 1'b1;
		period <= 8'h28;
		idle(1000);
		chk(window_ok === 1'b1, "one bad kept ok");
		rd(`FSW_ADDR_STATUS);
		chk(rd_data[1:0] === 2'h2, "count down");
		wait_ok(1'b0, 2000);
		idle(4);
		chk(enable_oe === 1'b1 && relay_oe === 1'b0, "fast gated");
		idle(900);
		rd(`FSW_ADDR_STATUS);
		chk(rd_data[1:0] === 2'h0, "count floor");
		$display("fast test done");
	endtask

	task t_good;
		relay_request <= 1'b0;
		get_ok();
		idle(4);
		chk(enable_oe === 1'b0 && relay_oe === 1'b0, "ok idle");
		relay_request <= 1'b1;
		idle(8);
		chk(relay_oe === 1'b1, "relay on");
		rd(`FSW_ADDR_STATUS);
		chk(rd_data === 32'h00000047, "count full");
		rd(`FSW_ADDR_PERIOD);
		chk(rd_data[7:0] === `FSW_TRIG_RATIO, "period");
		chk(irq === 1'b1, "irq raised");
		rd(`FSW_ADDR_IRQ_STAT);
		chk(rd_data[0] === 1'b1, "good event");
		idle(3);
		chk(irq === 1'b0, "irq cleared");
		wr(`FSW_ADDR_IRQ_MASK, 32'h00000000);
		idle(2200);
		chk(irq === 1'b0, "irq masked");
		rd(`FSW_ADDR_IRQ_STAT);
		chk(rd_data[0] === 1'b1, "masked event");
		relay_request <= 1'b0;
		wr(`FSW_ADDR_CTRL, 32'h00000001);
		rd(`FSW_ADDR_CTRL);
		chk(rd_data === 32'h00000001 && enable_oe === 1'b1, "force safe");
		chk(window_ok === 1'b1 && relay_oe === 1'b0, "force keeps ok");
		wr(`FSW_ADDR_CTRL, 32'h00000000);
		idle(2);
		chk(enable_oe === 1'b0, "force released");
		$display("good test done");
	endtask

	task t_osc;
		osc_run <= 1'b0;
		idle(1800);
		chk(window_ok === 1'b1, "early osc fail");
		wait_ok(1'b0, 400);
		rd(`FSW_ADDR_STATUS);
		chk(rd_data[3:0] === 4'h8, "osc status");
		osc_run <= 1'b1;
		$display("osc test done");
	endtask

	task t_supply;
		get_ok();
		undervolt_in <= 1'b1;
		idle(10);
		chk(reset_n === 1'b0 && relay_oe === 1'b0, "undervolt");
		chk(enable_oe === 1'b1 && window_ok === 1'b0, "wd init");
		undervolt_in <= 1'b0;
		idle(10);
		chk(reset_n === 1'b1, "supply back");
		overvolt_in <= 1'b1;
		idle(10);
		chk(reset_n === 1'b0 && enable_oe === 1'b1, "overvolt");
		overvolt_in <= 1'b0;
		$display("supply test done");
	endtask

	task t_drop;
		get_ok();
		period <= 8'h00;
		idle(4800);
		chk(window_ok === 1'b1, "early dropout");
		wait_ok(1'b0, 600);
		$display("dropout test done");
	endtask

	task t_slow;
		get_ok();
		relay_request <= 1'b1;
		period <= 8'hAA;
		idle(7200);
		chk(window_ok === 1'b1, "slow edge kept");
		rd(`FSW_ADDR_STATUS);
		chk(rd_data[1:0] === 2'h3, "slow edge good");
		period <= 8'hC8;
		wait_ok(1'b0, 13000);
		idle(4);
		chk(enable_oe === 1'b1 && relay_oe === 1'b0, "slow gated");
		$display("slow test done");
	endtask

	initial begin
		repeat (20) @(posedge clk_sys);
		reset <= 1'b0;
		@(posedge clk_sys);
		t_reset();
		t_fast();
		t_good();
		t_osc();
		t_supply();
		t_drop();
		t_slow();
		complete_run();
	end
endmodule // tb_top
